// ==== design/energy_pulse_output.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module energy_pulse_output
  import energy_pulse_pkg::*;
#(
  parameter int ACTIVE_CYCLES = ACTIVE_CYC,
  parameter int LONG_CYCLES   = LONG_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Energy LSB events and the apparent no-load flag from the metering path
  input  wire logic        active_lsb,
  input  wire logic        reactive_lsb,
  input  wire logic        apparent_lsb,
  input  wire logic        irms_lsb,
  input  wire logic        apparent_noload,
  // Outputs
  output logic             pulse_out_a_n,
  output logic             pulse_out_b_n,
  output logic             current_rms_sel,
  output logic             metering_interrupt,
  output logic      [15:0] irq_vector
);

  function automatic logic [15:0] as_one(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0001 : v; // [RL13] [RL15]
  endfunction

  // Register file
  logic [7:0]  first_mode_config_reg, first_mode_config_next;
  logic [7:0]  second_mode_config_reg, second_mode_config_next;
  logic [7:0]  en_low_reg, en_low_next;
  logic [7:0]  en_mid_reg, en_mid_next;
  logic [7:0]  en_high_reg, en_high_next;
  logic [7:0]  st_mid_reg, st_mid_next;
  logic [15:0] num_reg [2];
  logic [15:0] num_next [2];
  logic [15:0] den_reg [2];
  logic [15:0] den_next [2];
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  // Channel state
  ch_state_t        st_reg [2];
  ch_state_t        st_next [2];
  logic [16:0]      acc_reg [2];
  logic [16:0]      acc_next [2];
  logic [CNT_W-1:0] per_reg [2];
  logic [CNT_W-1:0] per_next [2];
  logic [CNT_W-1:0] low_reg [2];
  logic [CNT_W-1:0] low_next [2];
  logic [1:0]       out_n_reg, out_n_next;
  logic             irq_reg, irq_next;
  logic             irms_reg, irms_next;

  logic [1:0]  fire;
  logic [1:0]  dfc;
  logic [1:0]  dis;
  logic [15:0] num_eff [2];
  logic [15:0] den_eff [2];

  logic        acc_phase;
  logic        wr_done;
  logic [7:0]  idx;
  logic        hit;
  logic [31:0] rd_mux;

  // APB: one wait state, answer on second access cycle
  assign idx       = paddr[9:2];
  assign acc_phase = psel & penable & ~pready_reg;
  assign wr_done   = psel & penable & pready_reg & pwrite;

  always_comb begin
    hit    = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_FIRST_MODE_CONFIG:   rd_mux[7:0]  = first_mode_config_reg;
      IDX_SECOND_MODE_CONFIG:   rd_mux[7:0]  = second_mode_config_reg;
      IDX_EN_LOW:  rd_mux[7:0]  = en_low_reg;
      IDX_EN_MID:  rd_mux[7:0]  = en_mid_reg;
      IDX_EN_HIGH: rd_mux[7:0]  = en_high_reg;
      IDX_ST_MID:  rd_mux[7:0]  = st_mid_reg;
      IDX_NUM_A:   rd_mux[15:0] = num_reg[0];
      IDX_DEN_A:   rd_mux[15:0] = den_reg[0];
      IDX_NUM_B:   rd_mux[15:0] = num_reg[1];
      IDX_DEN_B:   rd_mux[15:0] = den_reg[1];
      default:     hit = 1'b0;
    endcase
  end

  always_comb begin
    pready_next  = acc_phase;
    pslverr_next = acc_phase & ~hit;
    prdata_next  = prdata_reg;
    if (acc_phase && !pwrite) begin
      prdata_next = hit ? rd_mux : 32'h0000_0000;
    end
  end

  always_comb begin
    first_mode_config_next   = first_mode_config_reg;
    second_mode_config_next   = second_mode_config_reg;
    en_low_next  = en_low_reg;
    en_mid_next  = en_mid_reg;
    en_high_next = en_high_reg;
    num_next     = num_reg;
    den_next     = den_reg;
    st_mid_next  = st_mid_reg;
    if (wr_done && hit) begin
      unique case (idx)
        IDX_FIRST_MODE_CONFIG:   first_mode_config_next   = pwdata[7:0];
        IDX_SECOND_MODE_CONFIG:   second_mode_config_next   = pwdata[7:0];
        IDX_EN_LOW:  en_low_next  = pwdata[7:0];               // [RL17]
        IDX_EN_MID:  en_mid_next  = pwdata[7:0];               // [RL17]
        IDX_EN_HIGH: en_high_next = pwdata[7:0];               // [RL17]
        IDX_ST_MID:  st_mid_next  = st_mid_reg & pwdata[7:0];  // [RL8]
        IDX_NUM_A:   num_next[0]  = pwdata[15:0];
        IDX_DEN_A:   den_next[0]  = pwdata[15:0];
        IDX_NUM_B:   num_next[1]  = pwdata[15:0];
        IDX_DEN_B:   den_next[1]  = pwdata[15:0];
        default:     first_mode_config_next   = first_mode_config_reg;
      endcase
    end
    // Set wins over a clear in the same cycle
    st_mid_next[ST_PULSE_A] = st_mid_next[ST_PULSE_A] | fire[0]; // [RL6]
    st_mid_next[ST_PULSE_B] = st_mid_next[ST_PULSE_B] | fire[1]; // [RL6]
    // Only mid status exists here; other groups contribute nothing
    irq_next  = |(st_mid_next & en_mid_next);                  // [RL7] [RL18]
    irms_next = second_mode_config_next[SECOND_MODE_CONFIG_IRMS];                        // [RL19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_mode_config_reg   <= RST_BYTE;
      second_mode_config_reg   <= RST_BYTE;
      en_low_reg  <= RST_BYTE;
      en_mid_reg  <= RST_BYTE;
      en_high_reg <= RST_BYTE;
      st_mid_reg  <= RST_BYTE;
      num_reg     <= '{RST_SCALE, RST_SCALE};
      den_reg     <= '{RST_SCALE, RST_SCALE};
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg     <= 1'b0;
      irms_reg    <= 1'b0;
    end else begin
      first_mode_config_reg   <= first_mode_config_next;
      second_mode_config_reg   <= second_mode_config_next;
      en_low_reg  <= en_low_next;
      en_mid_reg  <= en_mid_next;
      en_high_reg <= en_high_next;
      st_mid_reg  <= st_mid_next;
      num_reg     <= num_next;
      den_reg     <= den_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg     <= irq_next;
      irms_reg    <= irms_next;
    end
  end

  // Converter inputs and scaling
  assign dis[0] = first_mode_config_reg[FIRST_MODE_CONFIG_DIS_A];
  assign dis[1] = first_mode_config_reg[FIRST_MODE_CONFIG_DIS_B];

  always_comb begin
    logic [1:0] sel;
    sel = 2'b00;
    for (int i = 0; i < 2; i++) begin
      sel = (i == 0) ? second_mode_config_reg[SECOND_MODE_CONFIG_SEL_A +: 2]
                     : second_mode_config_reg[SECOND_MODE_CONFIG_SEL_B +: 2];
      // One shared bit serves both channels, so they cannot mix
      if (sel[1]) begin                                        // [RL3] [RL4]
        dfc[i] = irms_reg ? (irms_lsb & ~apparent_noload)      // [RL20]
                          : apparent_lsb;
      end else begin
        dfc[i] = sel[0] ? reactive_lsb : active_lsb;           // [RL1] [RL3]
      end
      den_eff[i] = as_one(den_reg[i]);                         // [RL13]
      num_eff[i] = (as_one(num_reg[i]) > den_eff[i]) ?         // [RL14]
                   den_eff[i] : as_one(num_reg[i]);            // [RL13]
    end
  end

  // Pulse scaling and shaping
  always_comb begin
    logic [16:0] sum;
    sum = 17'h0_0000;
    for (int i = 0; i < 2; i++) begin
      fire[i]     = 1'b0;
      acc_next[i] = acc_reg[i];
      st_next[i]  = st_reg[i];
      low_next[i] = low_reg[i];
      per_next[i] = per_reg[i];
      if (per_reg[i] != {CNT_W{1'b1}}) begin
        per_next[i] = per_reg[i] + 1'b1;
      end
      // Lit time keeps running while non-firing events accumulate
      if (st_reg[i] == CH_ACTIVE) begin
        if (low_reg[i] == '0) begin
          st_next[i] = CH_IDLE;
        end else begin
          low_next[i] = low_reg[i] - 1'b1;
        end
      end
      if (dfc[i] && !dis[i]) begin
        // Weighted count; fires once den/num internal pulses passed
        sum = acc_reg[i] + {1'b0, num_eff[i]};                 // [RL2] [RL12]
        if (sum >= {1'b0, den_eff[i]}) begin
          fire[i]     = 1'b1;                                  // [RL2]
          acc_next[i] = 17'h0_0000;                            // [RL21]
          per_next[i] = CNT_W'(1);
          st_next[i]  = CH_ACTIVE;
          if (per_reg[i] > CNT_W'(LONG_CYCLES)) begin
            low_next[i] = CNT_W'(ACTIVE_CYCLES - 1);           // [RL9]
          end else if (per_reg[i] > CNT_W'(3)) begin
            low_next[i] = (per_reg[i] >> 1) - 1'b1;            // [RL10]
          end else begin
            low_next[i] = '0;
          end
        end else begin
          acc_next[i] = sum;
        end
      end
      // Disabled output idles high
      if (dis[i]) begin                                        // [RL5]
        st_next[i]  = CH_IDLE;
        acc_next[i] = 17'h0_0000;
      end
      out_n_next[i] = (st_next[i] != CH_ACTIVE);               // [RL11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        st_reg[i]  <= CH_IDLE;
        acc_reg[i] <= 17'h0_0000;
        per_reg[i] <= '1;
        low_reg[i] <= '0;
      end
      out_n_reg <= 2'b11;
    end else begin
      for (int i = 0; i < 2; i++) begin
        st_reg[i]  <= st_next[i];
        acc_reg[i] <= acc_next[i];
        per_reg[i] <= per_next[i];
        low_reg[i] <= low_next[i];
      end
      out_n_reg <= out_n_next;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign pulse_out_a_n      = out_n_reg[0];
  assign pulse_out_b_n      = out_n_reg[1];
  assign current_rms_sel    = irms_reg;
  assign metering_interrupt = irq_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector <= 16'h0000;
    end else begin
      irq_vector <= IRQ_VECTOR;                                // [RL16]
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_st_clear_a;
    wr_done && hit && idx == IDX_ST_MID && !pwdata[ST_PULSE_A];
  endsequence

  sequence s_fire_b;
    fire[1] && !dis[1];
  endsequence

  sequence s_lit_ends_a;
    st_reg[0] == CH_ACTIVE && low_reg[0] == '0 && !fire[0];
  endsequence

  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence

  chk_disable_idle: assert property (                          // [RL5]
    dis[0] [*2] |-> pulse_out_a_n)
    else $error("Disabled output a not idle high");
  chk_flag_sets: assert property (                             // [RL6]
    fire[1] |=> st_mid_reg[ST_PULSE_B])
    else $error("Pulse b did not set its flag");
  chk_irq_holds: assert property (                             // [RL7]
    (st_mid_reg & en_mid_reg) != 8'h00 && $stable(st_mid_reg)
      && $stable(en_mid_reg) |-> metering_interrupt)
    else $error("Interrupt dropped while cause set");
  chk_clear_zero: assert property (                            // [RL8]
    s_st_clear_a and !fire[0] |=> !st_mid_reg[ST_PULSE_A])
    else $error("Zero write did not clear flag a");
  chk_irq_gated: assert property (                             // [RL18]
    en_mid_reg == 8'h00 |-> !metering_interrupt)
    else $error("Interrupt with no event enabled");
  chk_long_low: assert property (                              // [RL9]
    fire[0] && per_reg[0] > CNT_W'(LONG_CYCLES)
      |=> low_reg[0] == CNT_W'(ACTIVE_CYCLES - 1) && !pulse_out_a_n)
    else $error("Long period active time wrong");
  chk_half_duty: assert property (                             // [RL10]
    fire[0] && per_reg[0] <= CNT_W'(LONG_CYCLES) && per_reg[0] > CNT_W'(3)
      |=> low_reg[0] == ($past(per_reg[0]) >> 1) - 1'b1)
    else $error("Short period duty wrong");
  chk_ratio_clamp: assert property (                           // [RL13] [RL14]
    num_eff[0] != 16'h0000 && num_eff[0] <= den_eff[0])
    else $error("Effective ratio out of range");
  chk_restart: assert property (                               // [RL21]
    fire[0] |=> acc_reg[0] == 17'h0_0000)
    else $error("Count not restarted after pulse");
  chk_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle");
  chk_disable_idle_b: assert property (                        // [RL5]
    dis[1] [*2] |-> pulse_out_b_n)
    else $error("Disabled output b not idle high");
  chk_disabled_quiet: assert property (                        // [RL5]
    dis[0] |-> !fire[0])
    else $error("Disabled channel a produced a pulse");
  chk_flag_sets_a: assert property (                           // [RL6]
    fire[0] |=> st_mid_reg[ST_PULSE_A])
    else $error("Pulse a did not set its flag");
  chk_fall_b: assert property (                                // [RL11]
    s_fire_b |=> !pulse_out_b_n)
    else $error("Output b did not go low after a pulse");
  chk_lit_ends: assert property (                              // [RL10]
    s_lit_ends_a |=> pulse_out_a_n)
    else $error("Output a stayed low past its lit time");
  chk_irq_cause: assert property (                             // [RL6] [RL18]
    metering_interrupt == |(st_mid_reg & en_mid_reg))
    else $error("Interrupt does not match enabled flags");
  chk_count_holds: assert property (                           // [RL1]
    !dfc[0] && !dis[0] |=> acc_reg[0] == $past(acc_reg[0]))
    else $error("Count moved without an energy event");
  chk_count_steps: assert property (                           // [RL1] [RL2]
    dfc[0] && !dis[0] && !fire[0]
      |=> acc_reg[0] == $past(acc_reg[0]) + {1'b0, $past(num_eff[0])})
    else $error("Count did not step by the numerator");
  chk_vector_const: assert property (                          // [RL16]
    $past(presetn) |-> irq_vector == IRQ_VECTOR)
    else $error("Interrupt vector wrong");
  chk_apb_error: assert property (
    s_apb_wait and !hit |=> pslverr)
    else $error("Unmapped access not flagged");
  chk_write_lands: assert property (                           // [RL17]
    wr_done && hit && idx == IDX_EN_MID
      |=> en_mid_reg == $past(pwdata[7:0]))
    else $error("Enable write did not land");
  chk_rms_route: assert property (                             // [RL19]
    current_rms_sel == second_mode_config_reg[SECOND_MODE_CONFIG_IRMS])
    else $error("Current rms select not mirrored");
endmodule

// ==== inc/energy_pulse_pkg.sv ====
// Contract
// [RL1] Each converter emits one internal pulse per accumulated energy LSB.
// [RL2] Output pulse when internal pulse count reaches numerator/denominator ratio.
// [RL3] Source select 00 active, 01 reactive, 1x apparent or current rms.
// [RL4] One shared bit picks apparent or current rms for all 1x channels.
// [RL5] Output enabled when its disable bit is clear, disabled when set.
// [RL6] Each output sets its status flag; enabled flag posts metering interrupt.
// [RL7] Interrupt request stays asserted while the causing status bit is set.
// [RL8] Writing zero to a status bit clears it.
// [RL9] Period above 180 ms gives a fixed 90 ms active level.
// [RL10] Period below 180 ms gives a 50 percent duty cycle.
// [RL11] Both pulse outputs are active low, meant to drive an LED.
// [RL12] Unsigned 16-bit numerator and denominator scale by 1/2^16 to 1.
// [RL13] A numerator or denominator of zero acts as one.
// [RL14] Ratio above one is limited to one.
// [RL15] Unscaled full-scale output near 21.1 kHz with both scalers zero.
// [RL16] All metering interrupts share vector address 0x004b.
// [RL17] Three enable registers gate which metering events interrupt; here only the mid one gates, low and high are only stored.
// [RL18] An event whose enable bit is clear never interrupts.
// [RL19] Second_mode_config bit 3 selects current rms for apparent path and converter.
// [RL20] Apparent no-load threshold also gates the current rms pulse source.
// [RL21] Internal pulse count restarts from zero after each output pulse.
package energy_pulse_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIRST_MODE_CONFIG   = 8'h0b;
  localparam logic [7:0] IDX_SECOND_MODE_CONFIG   = 8'h0c;
  localparam logic [7:0] IDX_EN_LOW  = 8'hd9;
  localparam logic [7:0] IDX_EN_MID  = 8'hda;
  localparam logic [7:0] IDX_EN_HIGH = 8'hdb;
  localparam logic [7:0] IDX_ST_MID  = 8'hdd;
  localparam logic [7:0] IDX_NUM_A   = 8'h10;
  localparam logic [7:0] IDX_DEN_A   = 8'h11;
  localparam logic [7:0] IDX_NUM_B   = 8'h12;
  localparam logic [7:0] IDX_DEN_B   = 8'h13;
  // Field positions
  localparam int FIRST_MODE_CONFIG_DIS_A   = 0;
  localparam int FIRST_MODE_CONFIG_DIS_B   = 1;
  localparam int SECOND_MODE_CONFIG_IRMS    = 3;
  localparam int SECOND_MODE_CONFIG_SEL_A   = 4;
  localparam int SECOND_MODE_CONFIG_SEL_B   = 6;
  localparam int ST_PULSE_A    = 0;
  localparam int ST_PULSE_B    = 1;
  // Reset values and the fixed interrupt vector
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_SCALE = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR = 16'h004b;
  // Timing
  localparam int CLK_KHZ      = 100000;
  localparam int ACTIVE_MS    = 90;
  localparam int LONG_MS      = 180;
  localparam int ACTIVE_CYC   = ACTIVE_MS * CLK_KHZ;
  localparam int LONG_CYC     = LONG_MS * CLK_KHZ;
  localparam int CNT_W        = 25;
  typedef enum logic {CH_IDLE, CH_ACTIVE} ch_state_t;
endpackage

// ==== testbench/cal_receiver.sv ====
`timescale 1ns/1ps
module cal_receiver (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Optical line, LED lit while low
  input  wire logic        pulse_n,
  // Observations
  output logic      [31:0] pulse_count,
  output logic      [31:0] low_width
);
  logic        prev_reg;
  logic [31:0] run_reg;
  // Lit time measured from fall to rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg    <= 1'b1;
      run_reg     <= '0;
      pulse_count <= '0;
      low_width   <= '0;
    end else begin
      prev_reg <= pulse_n;
      run_reg  <= pulse_n ? 32'd0 : run_reg + 32'd1;
      if (prev_reg && !pulse_n) pulse_count <= pulse_count + 32'd1;
      if (!prev_reg && pulse_n) low_width <= run_reg;
    end
  end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import energy_pulse_pkg::*;
  localparam int ACT = 20;
  localparam int LNG = 40;
  logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, noload = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt_a, cnt_b, wid_a, wid_b;
  logic [31:0] seed = 32'd27891;
  logic [3:0]  lsb = 4'h0;
  logic        pa_n, pb_n, rms_sel, irq;
  logic [15:0] vec;
  logic [7:0]  first_mode_config = 8'h00, second_mode_config = 8'h00, en_mid = 8'h00;
  logic [1:0]  st_exp = 2'b00;
  logic [15:0] num [2] = '{16'h0, 16'h0};
  logic [15:0] den [2] = '{16'h0, 16'h0};
  int          acc [2] = '{0, 0};
  int          n_fail = 0, n_tests = 0, i;
  // Scaling cases: plain, clamped, zero, no-load, disabled
  logic [7:0]  t_m1 [6] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1};
  logic [7:0]  t_m2 [6] = '{8'h40, 8'he0, 8'he8, 8'he8, 8'h10, 8'h40};
  logic [15:0] t_na [6] = '{16'h1, 16'h5, 16'h0, 16'h0, 16'hffff, 16'h0};
  logic [15:0] t_da [6] = '{16'h3, 16'h2, 16'h4, 16'h4, 16'h0, 16'h0};
  logic [15:0] t_nb [6] = '{16'h0, 16'h2, 16'h3, 16'h3, 16'h1, 16'h0};
  logic [15:0] t_db [6] = '{16'h0, 16'h5, 16'h3, 16'h3, 16'h2, 16'h0};
  logic        t_nl [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

  energy_pulse_output #(.ACTIVE_CYCLES(ACT), .LONG_CYCLES(LNG))
    energy_pulse_output_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_lsb(lsb[0]),
    .reactive_lsb(lsb[1]), .apparent_lsb(lsb[2]), .irms_lsb(lsb[3]),
    .apparent_noload(noload), .pulse_out_a_n(pa_n),
    .pulse_out_b_n(pb_n), .current_rms_sel(rms_sel),
    .metering_interrupt(irq), .irq_vector(vec));
  cal_receiver rx_a (.pclk(pclk), .presetn(presetn), .pulse_n(pa_n),
                     .pulse_count(cnt_a), .low_width(wid_a));
  cal_receiver rx_b (.pclk(pclk), .presetn(presetn), .pulse_n(pb_n),
                     .pulse_count(cnt_b), .low_width(wid_b));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic hit(input int ch, input int src);
    logic [1:0] sel;
    sel = ch ? second_mode_config[SECOND_MODE_CONFIG_SEL_B +: 2] : second_mode_config[SECOND_MODE_CONFIG_SEL_A +: 2];
    if (first_mode_config[ch]) return 1'b0;
    if (sel == 2'b00) return src == 0;
    if (sel == 2'b01) return src == 1;
    if (second_mode_config[SECOND_MODE_CONFIG_IRMS]) return src == 3 && !noload;
    return src == 2;
  endfunction

  function automatic logic step(input int ch);
    int n, d;
    d = (den[ch] == 0) ? 1 : int'(den[ch]);
    n = (num[ch] == 0) ? 1 : int'(num[ch]);
    if (n > d) n = d;
    acc[ch] += n;
    if (acc[ch] < d) return 1'b0;
    acc[ch] = 0;
    return 1'b1;
  endfunction

  task automatic give_verdict;
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    case (idx)
      IDX_FIRST_MODE_CONFIG:  first_mode_config = d[7:0];
      IDX_SECOND_MODE_CONFIG:  second_mode_config = d[7:0];
      IDX_EN_MID: en_mid = d[7:0];
      IDX_ST_MID: st_exp &= d[1:0];
      IDX_NUM_A:  num[0] = d[15:0];
      IDX_DEN_A:  den[0] = d[15:0];
      IDX_NUM_B:  num[1] = d[15:0];
      IDX_DEN_B:  den[1] = d[15:0];
      default: ;
    endcase
    for (int c = 0; c < 2; c++) if (first_mode_config[c]) acc[c] = 0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic rreg(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // Negative src picks a random source per pulse
  task automatic drive(input int src, input int per, input int n);
    logic [31:0] a0, b0;
    int f [2];
    int s;
    a0 = cnt_a;
    b0 = cnt_b;
    f = '{0, 0};
    for (int k = 0; k < n; k++) begin
      seed = xs(seed);
      s = (src < 0) ? int'(seed[1:0]) : src;
      @(posedge pclk);
      lsb <= 4'b0001 << s;
      @(posedge pclk);
      lsb <= 4'b0000;
      for (int c = 0; c < 2; c++) if (hit(c, s) && step(c)) begin
        f[c]++;
        st_exp[c] = 1'b1;
      end
      repeat (per - 2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    // Short periods merge lit times, so counts only on long spacing
    if (per > 44) begin
      check(cnt_a - a0, f[0]);
      check(cnt_b - b0, f[1]);
      if (f[0] > 0) check(wid_a, ACT);
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(vec, IRQ_VECTOR);
    check({irq, rms_sel, pa_n, pb_n}, 32'h3);
    rreg(IDX_FIRST_MODE_CONFIG, 32'h0);
    rreg(IDX_ST_MID, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    seed = xs(seed);
    wreg(IDX_EN_LOW, {24'h0, seed[7:0]});
    rreg(IDX_EN_LOW, {24'h0, seed[7:0]});
    wreg(IDX_EN_HIGH, {24'h0, seed[15:8]});
    rreg(IDX_EN_HIGH, {24'h0, seed[15:8]});
    wreg(IDX_DEN_B, {16'h0, seed[31:16]});
    rreg(IDX_DEN_B, {16'h0, seed[31:16]});
    for (i = 0; i < 6; i++) begin
      wreg(IDX_FIRST_MODE_CONFIG, 32'h3);
      wreg(IDX_SECOND_MODE_CONFIG, {24'h0, t_m2[i]});
      wreg(IDX_NUM_A, {16'h0, t_na[i]});
      wreg(IDX_DEN_A, {16'h0, t_da[i]});
      wreg(IDX_NUM_B, {16'h0, t_nb[i]});
      wreg(IDX_DEN_B, {16'h0, t_db[i]});
      noload <= t_nl[i];
      wreg(IDX_FIRST_MODE_CONFIG, {24'h0, t_m1[i]});
      check(rms_sel, second_mode_config[SECOND_MODE_CONFIG_IRMS]);
      drive(-1, 50, 24);
      rreg(IDX_ST_MID, {30'h0, st_exp});
      check(irq, 1'b0);
    end
    wreg(IDX_EN_MID, 32'h3);
    check(irq, |st_exp);
    wreg(IDX_ST_MID, 32'h2);
    rreg(IDX_ST_MID, {30'h0, st_exp});
    check(irq, |st_exp);
    wreg(IDX_EN_MID, 32'h1);
    check(irq, st_exp[0]);
    wreg(IDX_ST_MID, 32'h0);
    check(irq, 1'b0);
    wreg(IDX_EN_MID, 32'h0);
    wreg(IDX_FIRST_MODE_CONFIG, 32'h3);
    wreg(IDX_SECOND_MODE_CONFIG, 32'h40);
    wreg(IDX_FIRST_MODE_CONFIG, 32'h0);
    drive(1, 12, 6);
    check(wid_b, 32'h6);
    drive(1, 60, 2);
    check(wid_b, ACT);
    give_verdict();
  end
endmodule
